// *** core/mme_pkg.sv ***
// Purpose: shared constants and types of the move and multiply execution unit
// Assumes: 16-bit program words, 12-bit data addresses, 8-bit data
// Notes:   register offsets are byte addresses on the register bus
package mme_pkg;
	// ============================================================
	// widths
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned WORD_W = 16;

	// ============================================================
	// instruction encodings
	localparam logic [3:0] PFX_MOVE_SRC   = 4'hC;  // first word of file-to-file move
	localparam logic [3:0] PFX_MOVE_DST   = 4'hF;  // second word of file-to-file move
	localparam logic [7:0] OPC_LOAD_BANK  = 8'h01;
	localparam logic [7:0] OPC_LOAD_ACC   = 8'h0E;
	localparam logic [7:0] OPC_MUL_LIT    = 8'h0D;
	localparam logic [6:0] OPC_STORE_ACC  = 7'h37;  // 0110 111
	localparam logic [6:0] OPC_MUL_FILE   = 7'h01;  // 0000 001
	localparam logic [7:0] INDEXED_MAX    = 8'h5F;  // highest offset using index base
	localparam logic [3:0] ACCESS_HI_PAGE = 4'hF;   // upper half of access bank
	localparam logic [3:0] ACCESS_LO_PAGE = 4'h0;

	// ============================================================
	// register map (byte offsets)
	localparam logic [4:0] REG_CTRL    = 5'h00;
	localparam logic [4:0] REG_ACC     = 5'h04;
	localparam logic [4:0] REG_BANK    = 5'h08;
	localparam logic [4:0] REG_PROD    = 5'h0C;
	localparam logic [4:0] REG_INDEX   = 5'h10;
	localparam logic [4:0] REG_STATUS  = 5'h14;
	localparam int unsigned CTRL_EXT_BIT   = 0;  // extended instruction set enable
	localparam int unsigned CTRL_RUN_BIT   = 1;  // accept instruction words
	localparam int unsigned STAT_PEND_BIT  = 0;  // move waits for its second word
	localparam int unsigned STAT_REFUSE_BIT = 1; // move to protected destination
	localparam int unsigned STAT_ORPHAN_BIT = 2; // lone second word seen
	localparam logic [1:0] CTRL_RESET  = 2'h0;
	localparam logic [7:0] BYTE_RESET  = 8'h00;
	localparam logic [11:0] INDEX_RESET = 12'h000;

	// ============================================================
	// types
	typedef enum logic [1:0] {
		PH_Q1 = 2'b00,
		PH_Q2 = 2'b01,
		PH_Q3 = 2'b10,
		PH_Q4 = 2'b11
	} mme_phase_t;

	typedef enum logic [2:0] {
		OP_NONE       = 3'b000,
		OP_MOVE_SRC   = 3'b001,
		OP_MOVE_DST   = 3'b010,
		OP_LOAD_BANK  = 3'b011,
		OP_LOAD_ACC   = 3'b100,
		OP_STORE_ACC  = 3'b101,
		OP_MUL_LIT    = 3'b110,
		OP_MUL_FILE   = 3'b111
	} mme_op_t;

	typedef struct packed {
		logic              en;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} mme_mem_req_t;
endpackage

// *** core/mme_exec.sv ***
// Purpose: decode and execute moves, literal loads and 8x8 multiplies
// Assumes: one instruction cycle is four clocks Q1..Q4; data memory read is
//          combinational within Q2, a write commits at the end of Q4
// Notes:   no arithmetic flags exist; this unit sets only the refused and orphan status flags
`timescale 1ns/10ps
`default_nettype none

module mme_exec
	import mme_pkg::*;
#(
	parameter logic [7:0]  ACCESS_SPLIT = 8'h80,  // access bank low/high boundary
	parameter logic [11:0] PC_LOW_ADDR  = 12'hFF9,
	parameter logic [11:0] TOS_LOW_ADDR = 12'hFFD,
	parameter logic [11:0] TOS_HIGH_ADDR = 12'hFFE,
	parameter logic [11:0] TOS_UP_ADDR  = 12'hFFF
) (
	input  wire logic              mclk_in,
	input  wire logic              resetn_in,
	// instruction word stream
	input  wire logic              instr_valid_in,
	input  wire logic [WORD_W-1:0] instr_in,
	output logic                   instr_ready_out,
	// data memory
	output mme_mem_req_t           mem_rd_out,
	input  wire logic [DATA_W-1:0] mem_rdata_in,
	output mme_mem_req_t           mem_wr_out,
	// core state
	output logic [DATA_W-1:0]      acc_out,
	output logic [DATA_W-1:0]      bank_out,
	output logic [WORD_W-1:0]      product_out,
	// register bus
	input  wire logic [4:0]        avs_address_in,
	input  wire logic              avs_read_in,
	input  wire logic              avs_write_in,
	input  wire logic [31:0]       avs_writedata_in,
	input  wire logic [3:0]        avs_byteenable_in,
	output logic [31:0]            avs_readdata_out,
	output logic                   avs_waitrequest_out
);
	// ============================================================
	// state
	mme_phase_t        q;
	mme_op_t           cur_op;
	logic [WORD_W-1:0] ir;
	logic              pending;
	logic [DATA_W-1:0] src_data;
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] acc;
	logic [DATA_W-1:0] bank;
	logic [DATA_W-1:0] prod_hi;
	logic [DATA_W-1:0] prod_lo;
	logic              ext_en;
	logic              run;
	logic [ADDR_W-1:0] index_base;
	logic              refused;
	logic              orphan;
	logic              av_ack;

	// ============================================================
	// effective address of a byte-oriented word
	function automatic logic [ADDR_W-1:0] file_addr(
		input logic [WORD_W-1:0] w,
		input logic              ext,
		input logic [DATA_W-1:0] bsel,
		input logic [ADDR_W-1:0] base
	);
		logic [7:0] f;
		logic       a;
		f = w[7:0];
		a = w[8];
		if (ext && !a && f <= INDEXED_MAX)
			file_addr = base + {4'h0, f};
		else if (a)
			file_addr = {bsel[3:0], f};
		else if (f < ACCESS_SPLIT)
			file_addr = {ACCESS_LO_PAGE, f};
		else
			file_addr = {ACCESS_HI_PAGE, f};
	endfunction

	// ============================================================
	// decode of the word offered in Q1
	wire is_move_src  = instr_in[15:12] == PFX_MOVE_SRC;
	wire is_move_dst  = instr_in[15:12] == PFX_MOVE_DST;
	wire is_load_bank = instr_in[15:8] == OPC_LOAD_BANK;
	wire is_load_acc  = instr_in[15:8] == OPC_LOAD_ACC;
	wire is_mul_lit   = instr_in[15:8] == OPC_MUL_LIT;
	wire is_store_acc = instr_in[15:9] == OPC_STORE_ACC;
	wire is_mul_file  = instr_in[15:9] == OPC_MUL_FILE;
	wire take         = instr_valid_in & instr_ready_out;
	// a destination word only counts while a source word waits for it
	wire orphan_dst   = take & is_move_dst & ~pending;
	mme_op_t dec_op;
	assign dec_op = (pending && is_move_dst) ? OP_MOVE_DST :
		is_move_dst  ? OP_NONE :
		is_move_src  ? OP_MOVE_SRC :
		is_load_bank ? OP_LOAD_BANK :
		is_load_acc  ? OP_LOAD_ACC :
		is_mul_lit   ? OP_MUL_LIT :
		is_store_acc ? OP_STORE_ACC :
		is_mul_file  ? OP_MUL_FILE : OP_NONE;
	wire dec_reads = take & (dec_op == OP_MOVE_SRC || dec_op == OP_MUL_FILE);
	wire [ADDR_W-1:0] dec_raddr = (dec_op == OP_MOVE_SRC) ? instr_in[11:0] :
		file_addr(instr_in, ext_en, bank, index_base);

	// ============================================================
	// execute-side selects
	wire [ADDR_W-1:0] dst_addr = ir[11:0];
	wire dst_protected = dst_addr == PC_LOW_ADDR || dst_addr == TOS_LOW_ADDR ||
		dst_addr == TOS_HIGH_ADDR || dst_addr == TOS_UP_ADDR;
	wire [DATA_W-1:0] mul_opnd = (cur_op == OP_MUL_FILE) ? rdata_q : ir[7:0];
	wire [WORD_W-1:0] product = {8'h00, acc} * {8'h00, mul_opnd};
	wire move_go  = cur_op == OP_MOVE_DST && !dst_protected;
	wire store_go = cur_op == OP_STORE_ACC;
	wire refuse_set = q == PH_Q3 && cur_op == OP_MOVE_DST && dst_protected;
	assign instr_ready_out = run && q == PH_Q1;

	// ============================================================
	// phase counter, free running so each cycle is four clocks
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in)
			q <= PH_Q1;
		else
			q <= mme_phase_t'(q + 2'b01);
	end

	// Q1: latch word; a late second word simply leaves the move pending
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ir <= 16'h0000;
			cur_op <= OP_NONE;
		end else if (q == PH_Q1) begin
			ir <= take ? instr_in : ir;
			cur_op <= take ? dec_op : OP_NONE;
		end
	end

	// Q2 read strobe; the second move cycle issues none
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in)
			mem_rd_out <= '0;
		else if (q == PH_Q1)
			mem_rd_out <= '{en: dec_reads, addr: dec_raddr, data: BYTE_RESET};
		else
			mem_rd_out <= '0;
	end

	// sample read data at the end of Q2
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rdata_q <= BYTE_RESET;
			src_data <= BYTE_RESET;
		end else if (q == PH_Q2 && mem_rd_out.en) begin
			rdata_q <= mem_rdata_in;
			src_data <= (cur_op == OP_MOVE_SRC) ? mem_rdata_in : src_data;
		end
	end

	// move bookkeeping: pending from its first word until the next word is taken
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in)
			pending <= 1'b0;
		else if (q == PH_Q1 && take)
			pending <= dec_op == OP_MOVE_SRC;
	end

	// Q4 write strobe, prepared at the end of Q3
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in)
			mem_wr_out <= '0;
		else if (q == PH_Q3 && move_go)
			mem_wr_out <= '{en: 1'b1, addr: dst_addr, data: src_data};
		else if (q == PH_Q3 && store_go)
			mem_wr_out <= '{en: 1'b1, addr: file_addr(ir, ext_en, bank, index_base),
				data: acc};
		else
			mem_wr_out <= '0;
	end

	// Q4 commit of core registers; no flag output exists to disturb
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			acc <= BYTE_RESET;
			bank <= BYTE_RESET;
			prod_hi <= BYTE_RESET;
			prod_lo <= BYTE_RESET;
		end else if (q == PH_Q4) begin
			acc <= (cur_op == OP_LOAD_ACC) ? ir[7:0] : acc;
			bank <= (cur_op == OP_LOAD_BANK) ? {bank[7:4], ir[3:0]} : bank;
			if (cur_op == OP_MUL_LIT || cur_op == OP_MUL_FILE) begin
				prod_hi <= product[15:8];
				prod_lo <= product[7:0];
			end
		end
	end

	assign acc_out = acc;
	assign bank_out = bank;
	assign product_out = {prod_hi, prod_lo};

	// ============================================================
	// register bus slave: every access waits exactly one clock
	wire av_req = avs_read_in | avs_write_in;
	wire av_wr_go = avs_write_in & av_ack;
	wire wr_ctrl = av_wr_go && avs_address_in == REG_CTRL && avs_byteenable_in[0];
	wire wr_idx_lo = av_wr_go && avs_address_in == REG_INDEX && avs_byteenable_in[0];
	wire wr_idx_hi = av_wr_go && avs_address_in == REG_INDEX && avs_byteenable_in[1];
	wire wr_stat = av_wr_go && avs_address_in == REG_STATUS && avs_byteenable_in[0];
	wire clr_refuse = wr_stat & avs_writedata_in[STAT_REFUSE_BIT];
	wire clr_orphan = wr_stat & avs_writedata_in[STAT_ORPHAN_BIT];
	logic [31:0] rd_mux;
	assign rd_mux =
		(avs_address_in == REG_CTRL)   ? {30'h0000_0000, run, ext_en} :
		(avs_address_in == REG_ACC)    ? {24'h00_0000, acc} :
		(avs_address_in == REG_BANK)   ? {24'h00_0000, bank} :
		(avs_address_in == REG_PROD)   ? {16'h0000, prod_hi, prod_lo} :
		(avs_address_in == REG_INDEX)  ? {20'h0_0000, index_base} :
		(avs_address_in == REG_STATUS) ? {29'h0000_0000, orphan, refused, pending} :
		32'h0000_0000;                                            // unmapped reads zero
	assign avs_waitrequest_out = av_req & ~av_ack;

	// handshake and read data
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			av_ack <= 1'b0;
			avs_readdata_out <= 32'h0000_0000;
		end else begin
			av_ack <= av_req & ~av_ack;
			avs_readdata_out <= (avs_read_in && !av_ack) ? rd_mux : avs_readdata_out;
		end
	end

	// software registers; a flag set by hardware wins over its clear
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			{run, ext_en} <= CTRL_RESET;
			index_base <= INDEX_RESET;
			refused <= 1'b0;
			orphan <= 1'b0;
		end else begin
			ext_en <= wr_ctrl ? avs_writedata_in[CTRL_EXT_BIT] : ext_en;
			run <= wr_ctrl ? avs_writedata_in[CTRL_RUN_BIT] : run;
			index_base[7:0] <= wr_idx_lo ? avs_writedata_in[7:0] : index_base[7:0];
			index_base[11:8] <= wr_idx_hi ? avs_writedata_in[11:8] : index_base[11:8];
			refused <= refuse_set | (refused & ~clr_refuse);
			orphan <= (q == PH_Q1 && orphan_dst) | (orphan & ~clr_orphan);
		end
	end

	// ============================================================
	// checks
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);

	AST_MOVE_NO_SECOND_READ: assert property (
		cur_op == OP_MOVE_DST |-> !mem_rd_out.en)
		else $error("second move cycle issued a read");
	AST_WRITE_IN_Q4: assert property (
		mem_wr_out.en |-> q == PH_Q4 && $past(q) == PH_Q3)
		else $error("write strobe outside Q4");
	AST_BANK_LOW_NIBBLE: assert property (
		q == PH_Q4 && cur_op == OP_LOAD_BANK |=>
		bank == {$past(bank[7:4]), $past(ir[3:0])})
		else $error("bank load wrong");
	AST_ACC_LOAD: assert property (
		q == PH_Q4 && cur_op == OP_LOAD_ACC |=> acc == $past(ir[7:0]))
		else $error("accumulator load wrong");
	AST_STORE_DATA: assert property (
		q == PH_Q3 && cur_op == OP_STORE_ACC |=> mem_wr_out.en && mem_wr_out.data == acc)
		else $error("store did not write accumulator");
	AST_BANKED_ADDR: assert property (
		q == PH_Q3 && cur_op == OP_STORE_ACC && ir[8] |=>
		mem_wr_out.addr == {$past(bank[3:0]), $past(ir[7:0])})
		else $error("banked address wrong");
	AST_INDEXED_ADDR: assert property (
		q == PH_Q3 && cur_op == OP_STORE_ACC && ext_en && !ir[8] && ir[7:0] <= INDEXED_MAX
		|=> mem_wr_out.addr == $past(index_base) + {4'h0, $past(ir[7:0])})
		else $error("indexed address wrong");
	AST_MUL_LIT: assert property (
		q == PH_Q4 && cur_op == OP_MUL_LIT |=>
		product_out == $past(acc) * $past(ir[7:0]) && $stable(acc))
		else $error("literal product wrong");
	AST_MUL_FILE: assert property (
		q == PH_Q2 && cur_op == OP_MUL_FILE |=> ##1 !mem_wr_out.en ##1
		product_out == $past(acc, 3) * $past(mem_rdata_in, 3))
		else $error("file product wrong");
	AST_PROTECTED_DST: assert property (
		cur_op == OP_MOVE_DST && dst_protected |-> !mem_wr_out.en)
		else $error("move wrote a protected register");
	AST_ORPHAN_NOP: assert property (
		q == PH_Q1 && orphan_dst |=> cur_op == OP_NONE ##2 !mem_wr_out.en)
		else $error("lone second word did something");

	// strobe placement and what the move carries across its two cycles
	AST_READ_IN_Q2: assert property (
		mem_rd_out.en |-> q == PH_Q2)
		else $error("read strobe outside Q2");
	AST_MOVE_DATA: assert property (
		q == PH_Q3 && move_go |=>
		mem_wr_out.en && mem_wr_out.data == $past(src_data) &&
		mem_wr_out.addr == $past(ir[11:0]))
		else $error("move wrote wrong place or value");

	// access bank split when the word is neither banked nor indexed
	AST_ACCESS_ADDR: assert property (
		q == PH_Q3 && cur_op == OP_STORE_ACC && !ir[8] &&
		!(ext_en && ir[7:0] <= INDEXED_MAX) |=>
		mem_wr_out.addr == {(($past(ir[7:0]) < ACCESS_SPLIT) ? ACCESS_LO_PAGE : ACCESS_HI_PAGE),
		$past(ir[7:0])})
		else $error("access bank address wrong");

	// core registers change only under their own instruction
	AST_ACC_KEPT: assert property (
		!(q == PH_Q4 && cur_op == OP_LOAD_ACC) |=> $stable(acc))
		else $error("accumulator changed without a load");
	AST_PROD_KEPT: assert property (
		!(q == PH_Q4 && (cur_op == OP_MUL_LIT || cur_op == OP_MUL_FILE))
		|=> $stable(product_out))
		else $error("product changed without a multiply");

	// software-visible flags follow their events
	AST_REFUSE_FLAG: assert property (
		refuse_set |=> refused)
		else $error("refused move not flagged");
	AST_ORPHAN_FLAG: assert property (
		q == PH_Q1 && orphan_dst |=> orphan)
		else $error("lone second word not flagged");

	COV_INDEXED_STORE: cover property (q == PH_Q3 && cur_op == OP_STORE_ACC && ext_en && !ir[8]);
	COV_MOVE_LATE: cover property (
		cur_op == OP_MOVE_SRC ##4 (pending && cur_op == OP_NONE));
	COV_MOVE_DONE: cover property (mem_wr_out.en && cur_op == OP_MOVE_DST);
	COV_MUL_FILE: cover property (q == PH_Q4 && cur_op == OP_MUL_FILE);
	COV_REFUSED: cover property (refuse_set);
endmodule // mme_exec

`default_nettype wire

// *** test/mme_exec_tb_top.sv ***
// Purpose: self-checking bench for the move and multiply execution unit
// Assumes: memory model answers reads in the Q2 clock; register bus answers by waitrequest
// Notes:   a bench model of acc, bank, product and memory is compared at every result
`timescale 1ns/10ps
`default_nettype none
module mme_exec_tb_top;
	import mme_pkg::*;
	// ============================================================
	// signals
	logic              mclk_in, resetn_in, instr_valid_in, instr_ready_out;
	logic [WORD_W-1:0] instr_in, product_out;
	mme_mem_req_t      mem_rd_out, mem_wr_out;
	logic [DATA_W-1:0] mem_rdata_in, acc_out, bank_out;
	logic [4:0]        avs_address_in;
	logic              avs_read_in, avs_write_in, avs_waitrequest_out;
	logic [31:0]       avs_writedata_in, avs_readdata_out, rd_q, seed;
	logic [3:0]        avs_byteenable_in;
	logic [7:0]        mem [4096];
	logic [7:0]        m_acc, m_bank, k, last_wd_q;
	logic [15:0]       m_prod;
	logic [11:0]       m_index, last_wa, last_ra, s_a, d_a;
	logic              m_ext;
	int                miscompares, compares, cyc, wr_cnt, rd_cnt, w0, r0;
	mme_exec dut_u (.mclk_in(mclk_in), .resetn_in(resetn_in), .instr_valid_in(instr_valid_in),
		.instr_in(instr_in), .instr_ready_out(instr_ready_out), .mem_rd_out(mem_rd_out),
		.mem_rdata_in(mem_rdata_in), .mem_wr_out(mem_wr_out), .acc_out(acc_out),
		.bank_out(bank_out), .product_out(product_out), .avs_address_in(avs_address_in),
		.avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
		.avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
		.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out));
	// ============================================================
	// clock, memory model and timeout
	always #10 mclk_in = ~mclk_in;
	// an idle read bus shows a changing pattern so a stale value cannot pass
	assign mem_rdata_in = mem_rd_out.en ? mem[mem_rd_out.addr] : (8'hA5 ^ cyc[7:0]);
	always @(posedge mclk_in) begin
		cyc <= cyc + 1;
		if (mem_rd_out.en) begin
			rd_cnt <= rd_cnt + 1;
			last_ra <= mem_rd_out.addr;
		end
		if (mem_wr_out.en) begin
			wr_cnt <= wr_cnt + 1;
			last_wa <= mem_wr_out.addr;
			last_wd_q <= mem_wr_out.data;
			mem[mem_wr_out.addr] <= mem_wr_out.data;
		end
		if (cyc == 20000) begin
			miscompares++;
			results();
		end
	end
	// ============================================================
	// helpers
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// bench view of the effective file address
	function automatic logic [11:0] ea(input logic a, input logic [7:0] f);
		if (a) return {m_bank[3:0], f};
		if (m_ext && f <= 8'h5F) return m_index + {4'h0, f};
		return (f < 8'h80) ? {4'h0, f} : {4'hF, f};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one bus request; held until waitrequest is sampled low at a rising edge
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_read_in <= !wr;
		avs_write_in <= wr;
		do begin
			@(posedge mclk_in);
			rd_q = avs_readdata_out;
		end while (avs_waitrequest_out);
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
	endtask
	task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		chk(rd_q, exp);
	endtask
	// offer one word, then let its Q4 commit land
	task automatic exec(input logic [15:0] w);
		@(posedge mclk_in);
		instr_valid_in <= 1'b1;
		instr_in <= w;
		do begin
			@(posedge mclk_in);
		end while (!instr_ready_out);
		instr_valid_in <= 1'b0;
		repeat (4) @(posedge mclk_in);
		@(negedge mclk_in);
	endtask
	task automatic results();
		if (miscompares == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// ============================================================
	// main sequence
	initial begin
		{mclk_in, resetn_in, instr_valid_in, avs_read_in, avs_write_in} = '0;
		{instr_in, avs_address_in, avs_writedata_in} = '0;
		avs_byteenable_in = 4'hF;
		{miscompares, compares, cyc, wr_cnt, rd_cnt} = '0;
		seed = 32'h0000_d3d4;
		{m_acc, m_bank, m_prod, m_index, m_ext} = '0;
		foreach (mem[i]) mem[i] = 8'(rnd());
		repeat (5) @(posedge mclk_in);
		resetn_in <= 1'b1;
		// reset values, unmapped place, and no intake before run is set
		for (int i = 0; i < 6; i++) rdchk(5'(4 * i), 32'h0000_0000);
		rdchk(5'h18, 32'h0000_0000);
		for (int i = 0; i < 4; i++) @(negedge mclk_in) chk(instr_ready_out, 0);
		bus(1'b1, REG_ACC, 32'h0000_00FF);
		bus(1'b1, REG_CTRL, 32'h0000_0002);
		rdchk(REG_CTRL, 32'h0000_0002);
		chk(acc_out, 0);
		// literal loads and bank nibble
		exec({8'h01, 8'hF5});
		m_bank = {m_bank[7:4], 4'h5};
		chk(bank_out, m_bank);
		// multiply by literal over corner and random operands
		for (int i = 0; i < 8; i++) begin
			m_acc = (i == 0) ? 8'hFF : 8'(rnd());
			k = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'(rnd());
			exec({OPC_LOAD_ACC, m_acc});
			chk(acc_out, m_acc);
			exec({OPC_MUL_LIT, k});
			m_prod = m_acc * k;
			chk(product_out, m_prod);
			chk(acc_out, m_acc);
		end
		rdchk(REG_PROD, {16'h0000, m_prod});
		// file multiply and store over both banks and indexed mode
		bus(1'b1, REG_INDEX, 32'h0000_0123);
		m_index = 12'h123;
		for (int e = 0; e < 2; e++) begin
			m_ext = e[0];
			bus(1'b1, REG_CTRL, {30'h0, 1'b1, m_ext});
			for (int i = 0; i < 6; i++) begin
				k = (i == 0) ? 8'h5F : (i == 1) ? 8'h60 : (i == 2) ? 8'h80 : 8'(rnd());
				d_a = ea(i[0] ^ i[2], k);
				exec({OPC_MUL_FILE, i[0] ^ i[2], k});
				m_prod = m_acc * mem[d_a];
				chk(last_ra, d_a);
				chk(product_out, m_prod);
				exec({OPC_STORE_ACC, i[0] ^ i[2], k});
				chk(last_wa, d_a);
				chk(last_wd_q, m_acc);
			end
		end
		// file-to-file move, back to back and with a late second word
		for (int g = 0; g < 2; g++) begin
			s_a = 12'(rnd());
			d_a = 12'(rnd()) & 12'hEFF;
			k = mem[s_a];
			r0 = rd_cnt;
			exec({PFX_MOVE_SRC, s_a});
			chk(last_ra, s_a);
			repeat (8 * g) @(posedge mclk_in);
			w0 = wr_cnt;
			exec({PFX_MOVE_DST, d_a});
			chk(rd_cnt, r0 + 1);
			chk(wr_cnt, w0 + 1);
			chk(last_wa, d_a);
			chk(last_wd_q, k);
		end
		// protected destinations are never written
		w0 = wr_cnt;
		for (int i = 0; i < 4; i++) begin
			exec({PFX_MOVE_SRC, 12'h010});
			exec({PFX_MOVE_DST, 12'hFF9 + 12'(i == 0 ? 0 : i + 3)});
		end
		chk(wr_cnt, w0);
		// a lone second word does nothing
		r0 = rd_cnt;
		exec({PFX_MOVE_DST, 12'h020});
		chk(wr_cnt, w0);
		chk(rd_cnt, r0);
		rdchk(REG_STATUS, 32'h0000_0006);
		// both flags clear by writing ones
		bus(1'b1, REG_STATUS, 32'h0000_0006);
		rdchk(REG_STATUS, 32'h0000_0000);
		chk(acc_out, m_acc);
		chk(bank_out, m_bank);
		results();
	end
endmodule // mme_exec_tb_top
`default_nettype wire
